// ### token_net_pkg.sv
// Function
// [RULE1] Host writes zero to undefined bits
// [RULE2] Mask bit sits at its flag's position
// [RULE3] Interrupt is OR of masked flags
// [RULE4] Masking hides, unmasking restores pending interrupt
// [RULE5] Each interrupt cleared by its own action
// [RULE6] Hardware reset zeroes the interrupt mask
// [RULE7] Data port moves bytes at pointer
// [RULE8] Low pointer write fetches one read byte
// [RULE9] High byte first; low byte applies address
// [RULE10] Probe match sets diagnostic flag
// [RULE11] Zero node identity keeps core asleep
// [RULE12] Nonzero identity wakes; transmit needs enable
// [RULE13] Successor update raises new-next flag
// [RULE14] Status takes default on any reset
// [RULE15] Diagnostic read clears all but two
// [RULE16] Excessive NAK clears by command, reset
// [RULE17] Command write starts the encoded command
// [RULE18] Configuration reset only by hardware
// [RULE19] Sub-select bits shared with configuration
// [RULE20] Third select bit; configuration write clears
// [RULE21] First setup cleared by hardware only
// [RULE22] Shared-address registers reached by sub-select
// [RULE23] Timeout bits select recon timer period
// [RULE24] Sub-select value map
package token_net_pkg;
   localparam logic [2:0] IDX_STATUS   = 3'h0;
   localparam logic [2:0] IDX_DIAG     = 3'h1;
   localparam logic [2:0] IDX_PTR_HIGH = 3'h2;
   localparam logic [2:0] IDX_PTR_LOW  = 3'h3;
   localparam logic [2:0] IDX_DATA     = 3'h4;
   localparam logic [2:0] IDX_SUBADDR  = 3'h5;
   localparam logic [2:0] IDX_CONFIG   = 3'h6;
   localparam logic [2:0] IDX_SHARED   = 3'h7;
   localparam logic [2:0] SUB_PROBE     = 3'h0;
   localparam logic [2:0] SUB_IDENTITY  = 3'h1;
   localparam logic [2:0] SUB_SPEED     = 3'h2;
   localparam logic [2:0] SUB_SUCCESSOR = 3'h3;
   localparam logic [2:0] SUB_SECOND_SETUP_REGISTER    = 3'h4;
   localparam int ST_RI = 7;
   localparam int ST_POR = 4;
   localparam int ST_RECON = 2;
   localparam int ST_TMA = 1;
   localparam int ST_TA = 0;
   localparam int DG_MYRECON = 7;
   localparam int DG_DUPLICATE_IDENTITY_FLAG = 6;
   localparam int DG_RCVACT = 5;
   localparam int DG_TOKEN = 4;
   localparam int DG_EXCESSIVE_NAK_FLAG = 3;
   localparam int DG_PROBE = 2;
   localparam int DG_NEWNEXT = 1;
   localparam int PH_RDDATA = 7;
   localparam int PH_AUTOINC = 6;
   localparam int CF_RESET = 7;
   localparam int CF_CCHEN = 6;
   localparam int CF_TRANSMIT_ENABLE_BIT = 5;
   localparam logic [7:0] DIAG_READ_KEEP = 8'h0a;
   localparam logic [7:0] IMR_RESET      = 8'h00;
   localparam logic [7:0] CONFIG_RESET   = 8'h18;
   localparam logic [7:0] STATUS_RESET   = 8'h91;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;
   localparam logic [2:0] SUB_RESET      = 3'h0;
   localparam logic [1:0] WORD_ALIGNED   = 2'h0;
   localparam logic [10:0] PTR_ONE       = 11'h001;
   localparam int CLK_KHZ = 125000;
   localparam int RECON_MS_SEL0 = 6720;
   localparam int RECON_MS_SEL1 = 1680;
   localparam int RECON_MS_SEL2 = 840;
   localparam int RECON_MS_SEL3 = 420;

   typedef struct packed {
      logic       rx_inhibit_set;
      logic       rx_inhibit_clear;
      logic       tx_avail_set;
      logic       tx_avail_clear;
      logic       tx_acked;
      logic       recon_seen;
      logic       my_recon;
      logic       dup_id;
      logic       rcv_activity;
      logic       token_seen;
      logic       exc_nak;
      logic       probe_match;
      logic       next_node_load;
      logic [7:0] next_node_value;
      logic [7:0] chain_status;
      logic       line_activity;
   } core_event_t;

   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } ram_req_t;

   typedef struct packed {
      logic       core_asleep;
      logic       transmit_allowed;
      logic       cmd_strobe;
      logic [7:0] cmd_code;
      logic [7:0] probe_id;
      logic [7:0] node_id;
      logic [7:0] setup1;
      logic [7:0] second_setup_register;
      logic [7:2] config_bits;
      logic       recon_expired;
   } core_ctrl_t;
endpackage : token_net_pkg

// ### token_net_host_register_file.sv
// The register addresses and register access over Avalon-MM were decided locally.
module token_net_host_register_file #(
   parameter logic [7:0] CLEAR_FLAGS_CODE = 8'h01,
   parameter logic [7:0] POR_CLEAR_CODE   = 8'h02,
   parameter int unsigned RECON_CYC0 =
      token_net_pkg::RECON_MS_SEL0 * token_net_pkg::CLK_KHZ,
   parameter int unsigned RECON_CYC1 =
      token_net_pkg::RECON_MS_SEL1 * token_net_pkg::CLK_KHZ,
   parameter int unsigned RECON_CYC2 =
      token_net_pkg::RECON_MS_SEL2 * token_net_pkg::CLK_KHZ,
   parameter int unsigned RECON_CYC3 =
      token_net_pkg::RECON_MS_SEL3 * token_net_pkg::CLK_KHZ
) (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic [4:0]                 address,
   input  wire logic                       read,
   input  wire logic                       write,
   input  wire logic [31:0]                writedata,
   input  wire logic [3:0]                 byteenable,
   output logic      [31:0]                readdata,
   output logic                            waitrequest,
   input  wire token_net_pkg::core_event_t core_event,
   input  wire logic [7:0]                 ram_rdata,
   output token_net_pkg::ram_req_t         ram_req,
   output token_net_pkg::core_ctrl_t       core_ctrl,
   output logic                            irq
);
   typedef struct packed {
      logic [7:0]  interrupt_enable_mask;
      logic        ri;
      logic        por;
      logic        recon;
      logic        tma;
      logic        ta;
      logic [7:0]  diag;
      logic [7:0]  ptr_stage;
      logic [10:0] ptr;
      logic [7:0]  data;
      logic [2:0]  subad;
      logic [7:2]  cfg;
      logic [7:0]  succ;
      logic        ack;
      logic        wait_n;
      logic [7:0]  rdata;
      logic        fetch1;
      logic        fetch2;
      logic [29:0] recon_cnt;
      logic        irq;
      token_net_pkg::ram_req_t   ram;
      token_net_pkg::core_ctrl_t ctrl;
   } state_t;

   state_t s;
   state_t next_s;
   logic [2:0]  idx;
   logic        mapped;
   logic        rd_fire;
   logic        wr_fire;
   logic        sw_rst;
   logic [7:0]  status_byte;
   logic [7:0]  rd_byte;
   logic [29:0] recon_limit;

   function automatic logic [7:0] irq_src(input state_t x);
      irq_src = 8'h00;
      irq_src[token_net_pkg::ST_RI]      = x.ri;
      irq_src[token_net_pkg::DG_EXCESSIVE_NAK_FLAG]  = x.diag[token_net_pkg::DG_EXCESSIVE_NAK_FLAG];
      irq_src[token_net_pkg::ST_RECON]   = x.recon;
      irq_src[token_net_pkg::DG_NEWNEXT] = x.diag[token_net_pkg::DG_NEWNEXT];
      irq_src[token_net_pkg::ST_TA]      = x.ta;
   endfunction : irq_src

   assign idx     = address[4:2];
   assign mapped  = address[1:0] == token_net_pkg::WORD_ALIGNED;
   assign rd_fire = read && s.ack;
   assign wr_fire = write && s.ack && mapped && byteenable[0];
   assign sw_rst  = s.cfg[token_net_pkg::CF_RESET];

   always_comb begin
      status_byte = 8'h00;
      status_byte[token_net_pkg::ST_RI]    = s.ri;
      status_byte[token_net_pkg::ST_POR]   = s.por;
      status_byte[token_net_pkg::ST_RECON] = s.recon;
      status_byte[token_net_pkg::ST_TMA]   = s.tma;
      status_byte[token_net_pkg::ST_TA]    = s.ta;
   end

   always_comb begin
      case (s.ctrl.second_setup_register[1:0])   // RULE23
         2'h0: recon_limit = 30'(RECON_CYC0);
         2'h1: recon_limit = 30'(RECON_CYC1);
         2'h2: recon_limit = 30'(RECON_CYC2);
         default: recon_limit = 30'(RECON_CYC3);
      endcase
   end

   always_comb begin
      rd_byte = token_net_pkg::ZERO_BYTE;
      if (mapped) begin
         case (idx)
            token_net_pkg::IDX_STATUS:
               rd_byte = s.ctrl.config_bits[token_net_pkg::CF_CCHEN] ?
                         core_event.chain_status : status_byte;   // RULE14
            token_net_pkg::IDX_DIAG:     rd_byte = s.diag;
            token_net_pkg::IDX_PTR_HIGH: rd_byte = {s.ptr_stage[7:6], 3'h0,
                                                    s.ptr[10:8]};
            token_net_pkg::IDX_PTR_LOW:  rd_byte = s.ptr[7:0];
            token_net_pkg::IDX_DATA:     rd_byte = s.data;   // RULE7
            token_net_pkg::IDX_SUBADDR:  rd_byte = {5'h00, s.subad};
            token_net_pkg::IDX_CONFIG:   rd_byte = {s.cfg, s.subad[1:0]};
            token_net_pkg::IDX_SHARED: begin
               case (s.subad)   // RULE22 RULE24
                  token_net_pkg::SUB_PROBE:     rd_byte = s.ctrl.probe_id;
                  token_net_pkg::SUB_IDENTITY:  rd_byte = s.ctrl.node_id;
                  token_net_pkg::SUB_SPEED:     rd_byte = s.ctrl.setup1;
                  token_net_pkg::SUB_SUCCESSOR: rd_byte = s.succ;
                  token_net_pkg::SUB_SECOND_SETUP_REGISTER:    rd_byte = s.ctrl.second_setup_register;
                  default:                      rd_byte = 8'h00;
               endcase
            end
            default: rd_byte = token_net_pkg::ZERO_BYTE;
         endcase
      end
   end

   always_comb begin
      next_s = s;
      next_s.ram.we = 1'b0;
      next_s.ram.re = 1'b0;
      next_s.ctrl.cmd_strobe = 1'b0;
      next_s.ctrl.recon_expired = 1'b0;
      next_s.fetch2 = s.fetch1;
      next_s.fetch1 = 1'b0;
      next_s.tma = core_event.tx_acked;
      if (s.fetch2) begin
         next_s.data = ram_rdata;   // RULE8
      end
      // Data-port reads stall while a fetch is still in flight
      next_s.ack = (read || write) && !s.ack &&
                   !(read && mapped && idx == token_net_pkg::IDX_DATA &&
                     (s.fetch1 || s.fetch2));
      next_s.wait_n = !next_s.ack;
      if (next_s.ack) begin
         next_s.rdata = rd_byte;
      end
      if (rd_fire && mapped) begin
         case (idx)
            token_net_pkg::IDX_DIAG:
               next_s.diag = s.diag & token_net_pkg::DIAG_READ_KEEP; // RULE15
            token_net_pkg::IDX_DATA: begin
               if (s.ptr_stage[token_net_pkg::PH_AUTOINC]) begin
                  next_s.ptr = s.ptr + token_net_pkg::PTR_ONE;
                  next_s.ram.addr = next_s.ptr;
                  next_s.ram.re = 1'b1;
                  next_s.fetch1 = 1'b1;
               end
            end
            token_net_pkg::IDX_SHARED: begin
               if (s.subad == token_net_pkg::SUB_SUCCESSOR) begin
                  next_s.diag[token_net_pkg::DG_NEWNEXT] = 1'b0;   // RULE5
               end
            end
            default: next_s.rdata = s.rdata;
         endcase
      end
      if (wr_fire) begin
         case (idx)
            token_net_pkg::IDX_STATUS: next_s.interrupt_enable_mask = writedata[7:0];   // RULE2
            token_net_pkg::IDX_DIAG: begin
               next_s.ctrl.cmd_strobe = 1'b1;   // RULE17
               next_s.ctrl.cmd_code = writedata[7:0];
               if (writedata[7:0] == CLEAR_FLAGS_CODE) begin
                  next_s.recon = 1'b0;   // RULE5
                  next_s.por = 1'b0;
               end
               if (writedata[7:0] == POR_CLEAR_CODE) begin
                  next_s.diag[token_net_pkg::DG_EXCESSIVE_NAK_FLAG] = 1'b0;   // RULE16
               end
            end
            token_net_pkg::IDX_PTR_HIGH: next_s.ptr_stage = writedata[7:0];
            token_net_pkg::IDX_PTR_LOW: begin
               next_s.ptr = {s.ptr_stage[2:0], writedata[7:0]};   // RULE9
               if (s.ptr_stage[token_net_pkg::PH_RDDATA]) begin
                  next_s.ram.addr = next_s.ptr;   // RULE8
                  next_s.ram.re = 1'b1;
                  next_s.fetch1 = 1'b1;
               end
            end
            token_net_pkg::IDX_DATA: begin
               next_s.ram.addr = s.ptr;   // RULE7
               next_s.ram.wdata = writedata[7:0];
               next_s.ram.we = 1'b1;
               next_s.data = writedata[7:0];
               if (s.ptr_stage[token_net_pkg::PH_AUTOINC]) begin
                  next_s.ptr = s.ptr + token_net_pkg::PTR_ONE;
               end
            end
            token_net_pkg::IDX_SUBADDR:
               next_s.subad = writedata[2:0];   // RULE19
            token_net_pkg::IDX_CONFIG: begin
               next_s.cfg = writedata[7:2];   // RULE18
               next_s.subad = {1'b0, writedata[1:0]};   // RULE19 RULE20
            end
            token_net_pkg::IDX_SHARED: begin
               case (s.subad)   // RULE22 RULE24
                  token_net_pkg::SUB_PROBE:
                     next_s.ctrl.probe_id = writedata[7:0];
                  token_net_pkg::SUB_IDENTITY: begin
                     next_s.ctrl.node_id = writedata[7:0];
                     if (writedata[7:0] == token_net_pkg::ZERO_BYTE) begin
                        next_s.por = 1'b1;
                     end
                  end
                  token_net_pkg::SUB_SPEED:
                     next_s.ctrl.setup1 = writedata[7:0];   // RULE21
                  token_net_pkg::SUB_SECOND_SETUP_REGISTER:
                     next_s.ctrl.second_setup_register = writedata[7:0];   // RULE23
                  default: next_s.ctrl.cmd_code = s.ctrl.cmd_code;
               endcase
            end
            default: next_s.interrupt_enable_mask = s.interrupt_enable_mask;
         endcase
      end
      // Core events are applied after host clears so a set wins
      if (core_event.rx_inhibit_clear) next_s.ri = 1'b0;
      if (core_event.rx_inhibit_set) next_s.ri = 1'b1;
      if (core_event.tx_avail_clear) next_s.ta = 1'b0;
      if (core_event.tx_avail_set) next_s.ta = 1'b1;
      if (core_event.recon_seen) next_s.recon = 1'b1;
      if (core_event.my_recon) next_s.diag[token_net_pkg::DG_MYRECON] = 1'b1;
      if (core_event.dup_id) next_s.diag[token_net_pkg::DG_DUPLICATE_IDENTITY_FLAG] = 1'b1;
      if (core_event.rcv_activity) next_s.diag[token_net_pkg::DG_RCVACT] = 1'b1;
      if (core_event.token_seen) next_s.diag[token_net_pkg::DG_TOKEN] = 1'b1;
      if (core_event.exc_nak) next_s.diag[token_net_pkg::DG_EXCESSIVE_NAK_FLAG] = 1'b1;
      if (core_event.probe_match) begin
         next_s.diag[token_net_pkg::DG_PROBE] = 1'b1;   // RULE10
      end
      if (core_event.next_node_load) begin
         next_s.succ = core_event.next_node_value;   // RULE13
         next_s.diag[token_net_pkg::DG_NEWNEXT] = 1'b1;
      end
      // Recon timer restarts on line activity or while asleep
      if (s.ctrl.core_asleep || core_event.line_activity) begin
         next_s.recon_cnt = 30'h0;
      end else if (s.recon_cnt >= recon_limit - 30'h1) begin
         next_s.recon_cnt = 30'h0;   // RULE23
         next_s.ctrl.recon_expired = 1'b1;
      end else begin
         next_s.recon_cnt = s.recon_cnt + 30'h1;
      end
      if (sw_rst) begin
         next_s.ri = 1'b1;   // RULE14
         next_s.por = 1'b1;
         next_s.recon = 1'b0;
         next_s.tma = 1'b0;
         next_s.ta = 1'b1;
         next_s.diag = token_net_pkg::ZERO_BYTE;   // RULE16
         next_s.succ = token_net_pkg::ZERO_BYTE;   // RULE13
      end
      next_s.ctrl.config_bits = next_s.cfg;
      next_s.ctrl.core_asleep =
         next_s.ctrl.node_id == token_net_pkg::ZERO_BYTE;   // RULE11
      next_s.ctrl.transmit_allowed = !next_s.ctrl.core_asleep &&
         next_s.cfg[token_net_pkg::CF_TRANSMIT_ENABLE_BIT] &&
         !next_s.cfg[token_net_pkg::CF_RESET];   // RULE12
      next_s.irq = |(next_s.interrupt_enable_mask & irq_src(next_s));   // RULE3 RULE4
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.interrupt_enable_mask <= token_net_pkg::IMR_RESET;   // RULE6
         s.ri <= 1'b1;
         s.por <= 1'b1;
         s.ta <= 1'b1;
         s.cfg <= token_net_pkg::CONFIG_RESET[7:2];
         s.subad <= {1'b0, token_net_pkg::CONFIG_RESET[1:0]};
         s.wait_n <= 1'b1;
         s.ctrl.config_bits <= token_net_pkg::CONFIG_RESET[7:2];
         s.ctrl.core_asleep <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign readdata    = {24'h000000, s.rdata};
   assign waitrequest = s.wait_n;
   assign ram_req     = s.ram;
   assign core_ctrl   = s.ctrl;
   assign irq         = s.irq;

   AST_IRQ_OR: assert property (@(posedge clk) disable iff (reset) // RULE3
      irq == |(s.interrupt_enable_mask & irq_src(s)))
      else $error("interrupt differs from masked flags");

   AST_IMR_RESET: assert property (@(posedge clk) // RULE6
      reset |=> (s.interrupt_enable_mask == token_net_pkg::IMR_RESET && !irq))
      else $error("mask not cleared by reset");

   AST_UNMASK: assert property (@(posedge clk) disable iff (reset) // RULE4
      (s.ri && $rose(s.interrupt_enable_mask[token_net_pkg::ST_RI])) |-> irq)
      else $error("pending flag not restored on unmask");

   AST_NEWNEXT_CLR: assert property (@(posedge clk) disable iff (reset) // RULE5
      (rd_fire && mapped && idx == token_net_pkg::IDX_SHARED &&
       s.subad == token_net_pkg::SUB_SUCCESSOR &&
       !core_event.next_node_load)
      |=> !s.diag[token_net_pkg::DG_NEWNEXT])
      else $error("successor read did not clear flag");

   AST_FETCH: assert property (@(posedge clk) disable iff (reset) // RULE8
      (wr_fire && idx == token_net_pkg::IDX_PTR_LOW &&
       s.ptr_stage[token_net_pkg::PH_RDDATA])
      |=> ram_req.re ##2 (s.data == $past(ram_rdata)))
      else $error("low pointer write did not fetch");

   AST_PTR_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE9
      (wr_fire && idx == token_net_pkg::IDX_PTR_HIGH) |=> $stable(s.ptr))
      else $error("high byte moved the pointer");

   AST_ASLEEP: assert property (@(posedge clk) disable iff (reset) // RULE11
      (s.ctrl.node_id == token_net_pkg::ZERO_BYTE)
      |-> (core_ctrl.core_asleep && !core_ctrl.transmit_allowed))
      else $error("core awake with zero identity");

   AST_TRANSMIT_ENABLE_BIT: assert property (@(posedge clk) disable iff (reset) // RULE12
      core_ctrl.transmit_allowed
      |-> (s.ctrl.node_id != 8'h00 && s.cfg[token_net_pkg::CF_TRANSMIT_ENABLE_BIT]))
      else $error("transmit allowed without enable");

   AST_DIAG_READ: assert property (@(posedge clk) disable iff (reset) // RULE15
      (rd_fire && mapped && idx == token_net_pkg::IDX_DIAG &&
       !core_event.my_recon && !core_event.dup_id &&
       !core_event.rcv_activity && !core_event.token_seen &&
       !core_event.probe_match)
      |=> ((s.diag & ~token_net_pkg::DIAG_READ_KEEP) == 8'h00))
      else $error("diagnostic read left flags set");

   AST_SHARED_SELECT_BIT2: assert property (@(posedge clk) disable iff (reset) // RULE20
      (wr_fire && idx == token_net_pkg::IDX_CONFIG) |=> !s.subad[2])
      else $error("configuration write kept third select bit");

   AST_SUCC: assert property (@(posedge clk) disable iff (reset) // RULE13
      (core_event.next_node_load && !sw_rst)
      |=> (s.succ == $past(core_event.next_node_value) &&
           s.diag[token_net_pkg::DG_NEWNEXT]))
      else $error("successor update lost");

   AST_SW_RESET: assert property (@(posedge clk) disable iff (reset) // RULE14
      sw_rst |=> (status_byte == token_net_pkg::STATUS_RESET &&
                  s.succ == 8'h00))
      else $error("software reset defaults wrong");

   AST_CMD: assert property (@(posedge clk) disable iff (reset) // RULE17
      (wr_fire && idx == token_net_pkg::IDX_DIAG)
      |=> (core_ctrl.cmd_strobe &&
           core_ctrl.cmd_code == $past(writedata[7:0])))
      else $error("command write not issued");

   AST_RAM_WRITE: assert property (@(posedge clk) disable iff (reset) // RULE7
      (wr_fire && idx == token_net_pkg::IDX_DATA)
      |=> (ram_req.we && ram_req.addr == $past(s.ptr) &&
           ram_req.wdata == $past(writedata[7:0])))
      else $error("data port write not passed to memory");

   AST_SUBAD: assert property (@(posedge clk) disable iff (reset) // RULE19
      (wr_fire && idx == token_net_pkg::IDX_SUBADDR)
      |=> (s.subad == $past(writedata[2:0])))
      else $error("sub-select write not stored");

   AST_EXCESSIVE_NAK_FLAG_KEEP: assert property (@(posedge clk) disable iff (reset) // RULE16
      (rd_fire && mapped && idx == token_net_pkg::IDX_DIAG &&
       s.diag[token_net_pkg::DG_EXCESSIVE_NAK_FLAG] && !sw_rst)
      |=> s.diag[token_net_pkg::DG_EXCESSIVE_NAK_FLAG])
      else $error("diagnostic read cleared excessive nak");

   AST_PROBE: assert property (@(posedge clk) disable iff (reset) // RULE10
      (core_event.probe_match && !sw_rst)
      |=> s.diag[token_net_pkg::DG_PROBE])
      else $error("probe match flag not set");
endmodule : token_net_host_register_file

// ### ram_model.sv
module ram_model (
   input  wire logic                    clk,
   input  wire token_net_pkg::ram_req_t ram_req,
   output logic [7:0]                   ram_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [2048];
   initial begin
      ram_rdata = 8'h00;
   end
   always @(posedge clk) begin
      if (ram_req.we) begin
         mem[ram_req.addr] <= ram_req.wdata;
      end
      // Read data lasts one cycle, then flips every cycle so a byte one cycle stale never matches
      if (ram_req.re) begin
         ram_rdata <= mem[ram_req.addr];
      end else begin
         ram_rdata <= ~ram_rdata;
      end
   end
endmodule : ram_model

// ### tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC3 = 10;
   logic                       clk;
   logic                       reset;
   logic [4:0]                 address;
   logic                       read;
   logic                       write;
   logic [31:0]                writedata;
   logic [31:0]                readdata;
   logic                       waitrequest;
   token_net_pkg::core_event_t core_event;
   token_net_pkg::core_event_t ev;
   logic [7:0]                 ram_rdata;
   token_net_pkg::ram_req_t    ram_req;
   token_net_pkg::core_ctrl_t  core_ctrl;
   logic                       irq;
   logic [7:0]                 d;
   int                         error_cnt;
   int                         n_checks;
   int                         cyc;
   int                         n_cmd;
   int                         last_exp;
   int                         gap;

   token_net_host_register_file #(
      .RECON_CYC0 (40),
      .RECON_CYC1 (30),
      .RECON_CYC2 (20),
      .RECON_CYC3 (RC3)
   ) i_token_net_host_register_file (
      .clk        (clk),
      .reset      (reset),
      .address    (address),
      .read       (read),
      .write      (write),
      .writedata  (writedata),
      .byteenable (4'h1),
      .readdata   (readdata),
      .waitrequest(waitrequest),
      .core_event (core_event),
      .ram_rdata  (ram_rdata),
      .ram_req    (ram_req),
      .core_ctrl  (core_ctrl),
      .irq        (irq)
   );

   ram_model i_ram_model (
      .clk      (clk),
      .ram_req  (ram_req),
      .ram_rdata(ram_rdata)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (core_ctrl.cmd_strobe === 1'b1) n_cmd <= n_cmd + 1;
      if (core_ctrl.recon_expired === 1'b1) begin
         gap <= cyc - last_exp;
         last_exp <= cyc;
      end
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rda(input logic [4:0] a, output logic [7:0] q);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
   endtask : rda

   task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      rda({idx, 2'h0}, q);
      check(q, exp);
   endtask : rdc

   task automatic wr(input logic [2:0] idx, input logic [7:0] v);
      @(posedge clk);
      address <= {idx, 2'h0};
      writedata <= {24'h0, v};
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : wr

   task automatic pulse();
      @(posedge clk);
      core_event <= ev;
      @(posedge clk);
      core_event <= '0;
      ev = '0;
      repeat (3) @(posedge clk);
   endtask : pulse

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      reset = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      core_event = '0;
      ev = '0;
      {error_cnt, n_checks, cyc, n_cmd, last_exp, gap} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rdc(3'h0, 8'h91);
      rdc(3'h1, 8'h00);
      rdc(3'h6, 8'h18);
      rdc(3'h7, 8'h00);
      check({7'h0, irq}, 8'h00);
      check({7'h0, core_ctrl.core_asleep}, 8'h01);
      $display("test reset done");
      wr(3'h0, 8'h01);
      settle();
      check({7'h0, irq}, 8'h01);
      wr(3'h0, 8'h00);
      settle();
      check({7'h0, irq}, 8'h00);
      wr(3'h0, 8'h81);
      settle();
      check({7'h0, irq}, 8'h01);
      ev.tx_avail_clear = 1'b1;
      ev.rx_inhibit_clear = 1'b1;
      pulse();
      check({7'h0, irq}, 8'h00);
      rdc(3'h0, 8'h10);
      wr(3'h0, 8'h04);
      ev.dup_id = 1'b1;
      pulse();
      check({7'h0, irq}, 8'h00);
      ev.recon_seen = 1'b1;
      pulse();
      check({7'h0, irq}, 8'h01);
      wr(3'h1, 8'h01);
      settle();
      check({7'h0, irq}, 8'h00);
      rdc(3'h0, 8'h00);
      wr(3'h0, 8'h08);
      {ev.exc_nak, ev.token_seen, ev.probe_match} = 3'h7;
      pulse();
      check({7'h0, irq}, 8'h01);
      rdc(3'h1, 8'h5c);
      rdc(3'h1, 8'h08);
      wr(3'h1, 8'h02);
      settle();
      check({7'h0, irq}, 8'h00);
      rdc(3'h1, 8'h00);
      check(n_cmd[7:0], 8'h02);
      check(core_ctrl.cmd_code, 8'h02);
      wr(3'h0, 8'h02);
      ev.next_node_load = 1'b1;
      ev.next_node_value = 8'h5a;
      pulse();
      check({7'h0, irq}, 8'h01);
      rdc(3'h1, 8'h02);
      wr(3'h5, 8'h03);
      rdc(3'h6, 8'h1b);
      rdc(3'h7, 8'h5a);
      settle();
      check({7'h0, irq}, 8'h00);
      $display("test interrupt done");
      wr(3'h2, 8'h45);
      wr(3'h3, 8'h10);
      wr(3'h4, 8'haa);
      wr(3'h4, 8'hbb);
      settle();
      check(i_ram_model.mem[11'h510], 8'haa);
      check(i_ram_model.mem[11'h511], 8'hbb);
      wr(3'h2, 8'hc5);
      wr(3'h3, 8'h10);
      rdc(3'h4, 8'haa);
      rdc(3'h4, 8'hbb);
      rda(5'h05, d);
      check(d, 8'h00);
      $display("test ram done");
      wr(3'h5, 8'h04);
      wr(3'h7, 8'h03);
      rdc(3'h7, 8'h03);
      rdc(3'h6, 8'h18);
      wr(3'h6, 8'h19);
      rdc(3'h5, 8'h01);
      wr(3'h7, 8'h07);
      settle();
      check(core_ctrl.node_id, 8'h07);
      check({7'h0, core_ctrl.core_asleep}, 8'h00);
      check({7'h0, core_ctrl.transmit_allowed}, 8'h00);
      wr(3'h6, 8'h39);
      settle();
      check({7'h0, core_ctrl.transmit_allowed}, 8'h01);
      check({2'h0, core_ctrl.config_bits}, 8'h0e);
      repeat (40) @(posedge clk);
      check({7'h0, gap == RC3 || gap == RC3 + 1}, 8'h01);
      wr(3'h7, 8'h00);
      wr(3'h6, 8'h1a);
      wr(3'h7, 8'h81);
      rdc(3'h7, 8'h81);
      wr(3'h6, 8'h18);
      wr(3'h7, 8'h22);
      settle();
      check(core_ctrl.probe_id, 8'h22);
      $display("test setup done");
      wr(3'h6, 8'h98);
      wr(3'h6, 8'h1b);
      rdc(3'h0, 8'h91);
      rdc(3'h1, 8'h00);
      rdc(3'h7, 8'h00);
      check(core_ctrl.setup1, 8'h81);
      check(core_ctrl.probe_id, 8'h22);
      @(posedge clk);
      reset <= 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rdc(3'h6, 8'h18);
      check(core_ctrl.setup1, 8'h00);
      check(core_ctrl.probe_id, 8'h00);
      check(core_ctrl.node_id, 8'h00);
      $display("test soft and hard reset done");
      stop_test();
   end
endmodule : tb
